// ===== rtl/tmr2_defs.svh
// Bit positions, reset values and register offsets for the second timer control block.
// Assumes inclusion by bare name from the rtl folder.
`ifndef TMR2_DEFS_SVH
`define TMR2_DEFS_SVH
`define TMR2_BIT_OVF      3'd7
`define TMR2_BIT_EXT      3'd6
`define TMR2_BIT_RXCLK    3'd5
`define TMR2_BIT_TXCLK    3'd4
`define TMR2_BIT_EXTEN    3'd3
`define TMR2_BIT_RUN      3'd2
`define TMR2_BIT_CNTSEL   3'd1
`define TMR2_BIT_CAPSEL   3'd0
`define TMR2_CTRL_RST     8'h00
`define TMR2_ADDR_CTRL    3'h0
`define TMR2_ADDR_CNT_LO  3'h1
`define TMR2_ADDR_CNT_HI  3'h2
`define TMR2_ADDR_RLD_LO  3'h3
`define TMR2_ADDR_RLD_HI  3'h4
`define TMR2_ADDR_BITSET  3'h5
`define TMR2_ADDR_BITCLR  3'h6
`define TMR2_ADDR_AUX     3'h7
`define TMR2_CNT_MAX      16'hffff
`define TMR2_ZERO16       16'h0000
`endif

// ===== rtl/tmr2_pkg.sv
// Types shared by the second timer control block.
// Assumes no other package.
package tmr2_pkg;
  typedef enum logic [1:0] {
    TMR2_EV_NONE    = 2'b00,
    TMR2_EV_RELOAD  = 2'b01,
    TMR2_EV_CAPTURE = 2'b10
  } tmr2_event_t;
endpackage : tmr2_pkg

// ===== rtl/tmr2_fall_sync.sv
// Two-stage synchroniser with falling-edge detector for one pin.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/1ps
module tmr2_fall_sync (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic pin_in,
  output logic      level,
  output logic      fall
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  // Pins idle high, so reset to one avoids a false fall after reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign level = sync_r;
  assign fall  = prev_r & ~sync_r;
endmodule : tmr2_fall_sync

// ===== rtl/tmr2_ctrl.sv
// Second timer: control register, 16-bit counter, reload/capture and serial clock select.
// Assumes the peripheral clock enable and serial overflow users are on ref_clk.
// Functional notes
// - Overflow flag set on overflow only when both serial clock selects are zero.
// - External flag set on trigger-pin capture or reload while trigger enabled.
// - External flag with timer interrupt enabled requests the interrupt until cleared.
// - Up/down count enable blocks the interrupt from the external flag.
// - Receive select picks this overflow, else first timer overflow, for serial rx.
// - Transmit select picks this overflow, else first timer overflow, for serial tx.
// - Trigger pin ignored when disabled or when timer clocks the serial port.
// - Run control zero stops counting, one lets it count.
// - Counter select zero counts peripheral clock, one counts count-pin falling edges.
// - Either serial clock select forces auto-reload, ignoring capture select.
// - Capture select zero reloads on overflow and on enabled trigger falls.
// - Capture select one with trigger enabled captures count on trigger falls.
// - Control register resets to zero and each bit is separately writable.
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "tmr2_defs.svh"
module tmr2_ctrl #(
  parameter int CNT_W = 16
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic [2:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              periph_clk_en,
  input  wire logic              count_input_pin,
  input  wire logic              ext_trigger_pin,
  input  wire logic              timer1_overflow,
  input  wire logic              timer_irq_enable,
  input  wire logic              updown_count_enable,
  output logic                   timer_irq,
  output logic                   serial_rx_clk,
  output logic                   serial_tx_clk,
  output logic                   overflow_pulse
);
  logic [7:0]       timer_control_reg_r;
  logic [7:0]       ctrl_nxt;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] reload_r;
  logic             cnt_level;
  logic             cnt_fall;
  logic             ex_level;
  logic             ex_fall;
  logic             overflow_flag;
  logic             ext_event_flag;
  logic             rx_clock_select;
  logic             tx_clock_select;
  logic             ext_trigger_enable;
  logic             run_control;
  logic             counter_select;
  logic             capture_reload_select;
  logic             serial_mode;
  logic             tick;
  logic             ovf;
  logic             trig;
  logic             cnt_wr_lo;
  logic             cnt_wr_hi;
  tmr2_pkg::tmr2_event_t ev;

  tmr2_fall_sync u_cnt_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin_in  (count_input_pin),
    .level   (cnt_level),
    .fall    (cnt_fall)
  );

  tmr2_fall_sync u_ex_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin_in  (ext_trigger_pin),
    .level   (ex_level),
    .fall    (ex_fall)
  );

  assign overflow_flag         = timer_control_reg_r[`TMR2_BIT_OVF];
  assign ext_event_flag        = timer_control_reg_r[`TMR2_BIT_EXT];
  assign rx_clock_select       = timer_control_reg_r[`TMR2_BIT_RXCLK];
  assign tx_clock_select       = timer_control_reg_r[`TMR2_BIT_TXCLK];
  assign ext_trigger_enable    = timer_control_reg_r[`TMR2_BIT_EXTEN];
  assign run_control           = timer_control_reg_r[`TMR2_BIT_RUN];
  assign counter_select        = timer_control_reg_r[`TMR2_BIT_CNTSEL];
  assign capture_reload_select = timer_control_reg_r[`TMR2_BIT_CAPSEL];

  assign serial_mode = rx_clock_select | tx_clock_select;

  // Counter select must stay zero in clock-out mode; the block does not police it
  assign tick = run_control & (counter_select ? cnt_fall : periph_clk_en);
  assign ovf  = tick & (count_r == CNT_W'(`TMR2_CNT_MAX));

  // Trigger is dead while the timer drives the serial port
  assign trig = ex_fall & ext_trigger_enable & ~serial_mode;

  always_comb begin
    ev = tmr2_pkg::TMR2_EV_NONE;
    if (trig && capture_reload_select) begin
      ev = tmr2_pkg::TMR2_EV_CAPTURE;
    end else if (trig) begin
      ev = tmr2_pkg::TMR2_EV_RELOAD;
    end
  end

  assign cnt_wr_lo = reg_wr & (reg_addr == `TMR2_ADDR_CNT_LO);
  assign cnt_wr_hi = reg_wr & (reg_addr == `TMR2_ADDR_CNT_HI);

  // Control register: software writes whole byte or single bits, hardware set wins
  always_comb begin
    ctrl_nxt = timer_control_reg_r;
    if (reg_wr && reg_addr == `TMR2_ADDR_CTRL) begin
      ctrl_nxt = reg_wdata;
    end else if (reg_wr && reg_addr == `TMR2_ADDR_BITSET) begin
      ctrl_nxt[reg_wdata[2:0]] = 1'b1;
    end else if (reg_wr && reg_addr == `TMR2_ADDR_BITCLR) begin
      ctrl_nxt[reg_wdata[2:0]] = 1'b0;
    end
    if (ovf && !serial_mode) begin
      ctrl_nxt[`TMR2_BIT_OVF] = 1'b1;
    end
    if (ev != tmr2_pkg::TMR2_EV_NONE) begin
      ctrl_nxt[`TMR2_BIT_EXT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      timer_control_reg_r <= `TMR2_CTRL_RST;
    end else begin
      timer_control_reg_r <= ctrl_nxt;
    end
  end

  // Counter: reload on overflow (forced in serial mode) or on a reload trigger
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_r <= CNT_W'(`TMR2_ZERO16);
    end else if (cnt_wr_lo) begin
      count_r[7:0] <= reg_wdata;
    end else if (cnt_wr_hi) begin
      count_r[CNT_W-1:8] <= reg_wdata[CNT_W-9:0];
    end else if (ev == tmr2_pkg::TMR2_EV_RELOAD) begin
      count_r <= reload_r;
    end else if (ovf && (serial_mode || !capture_reload_select)) begin
      count_r <= reload_r;
    end else if (tick) begin
      count_r <= count_r + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reload_r <= CNT_W'(`TMR2_ZERO16);
    end else if (ev == tmr2_pkg::TMR2_EV_CAPTURE) begin
      reload_r <= count_r;
    end else if (reg_wr && reg_addr == `TMR2_ADDR_RLD_LO) begin
      reload_r[7:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == `TMR2_ADDR_RLD_HI) begin
      reload_r[CNT_W-1:8] <= reg_wdata[CNT_W-9:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `TMR2_ADDR_CTRL:   reg_rdata <= timer_control_reg_r;
        `TMR2_ADDR_CNT_LO: reg_rdata <= count_r[7:0];
        `TMR2_ADDR_CNT_HI: reg_rdata <= count_r[CNT_W-1:8];
        `TMR2_ADDR_RLD_LO: reg_rdata <= reload_r[7:0];
        `TMR2_ADDR_RLD_HI: reg_rdata <= reload_r[CNT_W-1:8];
        `TMR2_ADDR_AUX:    reg_rdata <= {6'h00, ex_level, cnt_level};
        default:           reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Serial clocks and interrupt are registered to keep them glitch free
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      serial_rx_clk  <= 1'b0;
      serial_tx_clk  <= 1'b0;
      overflow_pulse <= 1'b0;
      timer_irq      <= 1'b0;
    end else begin
      serial_rx_clk  <= rx_clock_select ? ovf : timer1_overflow;
      serial_tx_clk  <= tx_clock_select ? ovf : timer1_overflow;
      overflow_pulse <= ovf;
      timer_irq      <= timer_irq_enable &
                        (ctrl_nxt[`TMR2_BIT_OVF] |
                         (ctrl_nxt[`TMR2_BIT_EXT] & ~updown_count_enable));
    end
  end
endmodule : tmr2_ctrl

// ===== verif/tmr2_pins.sv
// Far-side model: trigger and count pins idling high, and the first timer's overflow.
// Assumes one-cycle go pulses from the bench, on ref_clk.
`timescale 1ns/1ps
module tmr2_pins (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic trig_go,
  input  wire logic cnt_go,
  output logic      ext_trigger_pin,
  output logic      count_input_pin,
  output logic      timer1_overflow
);
  logic [2:0] t1_r;
  logic [1:0] trig_r;
  logic [1:0] cnt_r;
  // Pins are pulled high when idle; a go drops them low for two cycles
  always_ff @(posedge ref_clk) begin
    t1_r   <= reset ? 3'h0 : t1_r + 3'h1;
    trig_r <= trig_go ? 2'h2 : (trig_r != 2'h0 ? trig_r - 2'h1 : 2'h0);
    cnt_r  <= cnt_go ? 2'h2 : (cnt_r != 2'h0 ? cnt_r - 2'h1 : 2'h0);
  end
  assign timer1_overflow = (t1_r == 3'h7);
  assign ext_trigger_pin = (trig_r == 2'h0);
  assign count_input_pin = (cnt_r == 2'h0);
endmodule : tmr2_pins

// ===== verif/tmr2_ctrl_chk.sv
// Port-level checker for the second timer control block.
// Assumes binding to tmr2_ctrl; one clock domain.
`timescale 1ns/1ps
module tmr2_ctrl_chk #(
  parameter int CNT_W = 16
) (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic [2:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       periph_clk_en,
  input wire logic       count_input_pin,
  input wire logic       timer1_overflow,
  input wire logic       timer_irq_enable,
  input wire logic       timer_irq,
  input wire logic       serial_rx_clk,
  input wire logic       serial_tx_clk,
  input wire logic       overflow_pulse
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  AST_RST: assert property ($fell(reset) |-> reg_rdata == 8'h00 && !timer_irq && !overflow_pulse)
    else $error("outputs not clear after reset");
  AST_RDIDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read");
  AST_IRQ_OFF: assert property (!timer_irq_enable |=> !timer_irq)
    else $error("interrupt while disabled");
  AST_TX: assert property (serial_tx_clk |-> $past(timer1_overflow) || overflow_pulse)
    else $error("transmit clock without source");
  AST_RX: assert property (serial_rx_clk |-> $past(timer1_overflow) || overflow_pulse)
    else $error("receive clock without source");
  // Seven quiet cycles cover the pin synchroniser delay
  AST_QUIET: assert property ((!periph_clk_en && count_input_pin)[*7] |=> !overflow_pulse)
    else $error("overflow without any tick");
  AST_RSV: assert property (reg_rd && (reg_addr == 3'h5 || reg_addr == 3'h6) |=> reg_rdata == 8'h00)
    else $error("set or clear port reads nonzero");
  AST_AUX: assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata[7:2] == 6'h00)
    else $error("pin level port upper bits set");
endmodule : tmr2_ctrl_chk
bind tmr2_ctrl tmr2_ctrl_chk #(.CNT_W(CNT_W)) u_chk (.ref_clk(ref_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_clk_en(periph_clk_en),
  .count_input_pin(count_input_pin), .timer1_overflow(timer1_overflow),
  .timer_irq_enable(timer_irq_enable), .timer_irq(timer_irq), .serial_rx_clk(serial_rx_clk),
  .serial_tx_clk(serial_tx_clk), .overflow_pulse(overflow_pulse));

// ===== verif/tmr2_ctrl_tb_top.sv
// Self-checking bench for the second timer control block.
// Assumes the pin model in tmr2_pins and a checker bound by its own file.
`timescale 1ns/1ps
module tmr2_ctrl_tb_top;
  logic ref_clk, reset, reg_wr, reg_rd, periph_clk_en, timer_irq_enable, updown_count_enable;
  logic trig_go, cnt_go, rd_d, ext_trigger_pin, count_input_pin, timer1_overflow;
  logic timer_irq, serial_rx_clk, serial_tx_clk, overflow_pulse;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, b;
  logic [7:0] q[$];
  int failures, n_tests, cyc, seed;
  int n_ovf, n_rx, n_tx, s_rx, s_tx;
  tmr2_ctrl dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_clk_en(periph_clk_en),
    .count_input_pin(count_input_pin), .ext_trigger_pin(ext_trigger_pin),
    .timer1_overflow(timer1_overflow), .timer_irq_enable(timer_irq_enable),
    .updown_count_enable(updown_count_enable), .timer_irq(timer_irq),
    .serial_rx_clk(serial_rx_clk), .serial_tx_clk(serial_tx_clk), .overflow_pulse(overflow_pulse));
  tmr2_pins u_pins (.ref_clk(ref_clk), .reset(reset), .trig_go(trig_go), .cnt_go(cnt_go),
    .ext_trigger_pin(ext_trigger_pin), .count_input_pin(count_input_pin),
    .timer1_overflow(timer1_overflow));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // Read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_d) chk("rdata", q.pop_front(), reg_rdata);
    rd_d <= reg_rd;
    // Pulse counters update late in the step so a snapshot sees whole edges
    n_ovf <= n_ovf + int'(overflow_pulse);
    n_rx <= n_rx + int'(serial_rx_clk);
    n_tx <= n_tx + int'(serial_tx_clk);
    cyc++;
    if (cyc == 5000) begin
      failures++;
      give_verdict();
    end
  end
  task wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; @(posedge ref_clk);
    reg_wr <= 1'b0; @(posedge ref_clk);
  endtask : wr
  task rd(input logic [2:0] a, input logic [7:0] e);
    q.push_back(e); reg_addr <= a; reg_rd <= 1'b1; @(posedge ref_clk);
    reg_rd <= 1'b0; @(posedge ref_clk);
  endtask : rd
  task w16(input logic [2:0] a, input logic [15:0] v);
    wr(a, v[7:0]); wr(a + 3'h1, v[15:8]);
  endtask : w16
  task rd16(input logic [2:0] a, input logic [15:0] v);
    rd(a, v[7:0]); rd(a + 3'h1, v[15:8]);
  endtask : rd16
  task tick(input int n);
    periph_clk_en <= 1'b1; repeat (n) @(posedge ref_clk);
    periph_clk_en <= 1'b0; @(posedge ref_clk);
  endtask : tick
  // Pin events need about three edges to pass the synchroniser
  task pin(input bit t);
    if (t) trig_go <= 1'b1; else cnt_go <= 1'b1;
    @(posedge ref_clk); trig_go <= 1'b0; cnt_go <= 1'b0; repeat (6) @(posedge ref_clk);
  endtask : pin
  initial begin
    {reg_wr, reg_rd, periph_clk_en, timer_irq_enable, updown_count_enable} = 5'h00;
    {trig_go, cnt_go, rd_d} = 3'h0; reg_addr = 3'h0; reg_wdata = 8'h00; reset = 1'b1;
    seed = 34164; failures = 0; n_tests = 0; cyc = 0;
    n_ovf = 0; n_rx = 0; n_tx = 0; s_rx = 0; s_tx = 0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0; @(posedge ref_clk);
    rd(0, 8'h00); rd16(1, 16'h0000); rd(5, 8'h00); rd(7, 8'h03);
    s_rx = n_rx;
    s_tx = n_tx;
    // First timer overflows once every eight cycles in the pin model
    repeat (16) @(posedge ref_clk);
    chk("rx_from_t1", 8'h02, 8'(n_rx - s_rx));
    chk("tx_from_t1", 8'h02, 8'(n_tx - s_tx));
    for (int i = 0; i < 8; i++) begin
      wr(5, 8'(i)); rd(0, 8'h01 << i); wr(6, 8'(i)); rd(0, 8'h00);
    end
    b = 8'($random(seed)) & 8'h7f;
    w16(1, {8'h00, b}); tick(4); rd(1, b);
    wr(0, 8'h04); tick(5); wr(0, 8'h00); rd(1, b + 8'h05);
    w16(3, 16'h1234); w16(1, 16'hffff); wr(0, 8'h04); tick(1); wr(6, 2);
    rd(0, 8'h80); rd16(1, 16'h1234);
    w16(1, 16'hffff); wr(0, 8'h35);
    @(posedge ref_clk);
    s_rx = n_rx;
    s_tx = n_tx;
    tick(1); wr(6, 2);
    chk("rx_from_t2", 8'h01, 8'(n_rx - s_rx));
    chk("tx_from_t2", 8'h01, 8'(n_tx - s_tx));
    rd(0, 8'h31); rd16(1, 16'h1234);
    w16(1, 16'h5678); wr(0, 8'h09); pin(1); rd(0, 8'h49); rd16(3, 16'h5678);
    timer_irq_enable <= 1'b1; repeat (3) @(posedge ref_clk); chk("irq", 8'h01, timer_irq);
    updown_count_enable <= 1'b1; repeat (3) @(posedge ref_clk); chk("irq", 8'h00, timer_irq);
    timer_irq_enable <= 1'b0; updown_count_enable <= 1'b0;
    w16(3, 16'h4321); wr(0, 8'h08); pin(1); rd(0, 8'h48); rd16(1, 16'h4321);
    wr(0, 8'h01); w16(1, 16'h0000); pin(1); rd(0, 8'h01); rd16(1, 16'h0000);
    wr(0, 8'h18); pin(1); rd(0, 8'h18);
    w16(1, 16'h0000); wr(0, 8'h06); repeat (3) pin(0); wr(0, 8'h00); rd(1, 8'h03);
    repeat (2) @(posedge ref_clk);
    chk("ovf_pulses", 8'h02, 8'(n_ovf));
    give_verdict();
  end
endmodule : tmr2_ctrl_tb_top
